/* des_unit_consts.vh */
// Constants for the DES unit host interface: register byte addresses,
// field positions, legal codes, reset values and error flag positions.
// Assumes a 32-bit classic Wishbone slave with byte addresses on 8 bits.
`ifndef DES_UNIT_CONSTS_VH
`define DES_UNIT_CONSTS_VH

// Register byte addresses
`define A_MODE     8'h00
`define A_KLEN     8'h04
`define A_MLEN     8'h08
`define A_RSTC     8'h0C
`define A_STAT     8'h10
`define A_EFLG     8'h14
`define A_EMSK     8'h18
`define A_GO       8'h1C
`define A_IVH      8'h20
`define A_IVL      8'h24
`define A_K1H      8'h28
`define A_K1L      8'h2C
`define A_K2H      8'h30
`define A_K2L      8'h34
`define A_K3H      8'h38
`define A_K3L      8'h3C

// Queue window: any address with this bit set
`define FIFO_BIT   7
// Word select inside the window: clear = high half, set = low half
`define HALF_BIT   2

// Mode register fields
`define MODE_TDES  0
`define MODE_CBC   1
`define MODE_W     3
`define MODE_LEGAL 32'h0000_0007

// Key length codes in bytes
`define KLEN_1DES  8'h08
`define KLEN_2KEY  8'h10
`define KLEN_3KEY  8'h18

// Message length in bits; these low bits must be clear
`define MLEN_CHK   32'h0000_003F
`define MLEN_SHIFT 6

// Reset control bits, self-clearing
`define RC_SR      0
`define RC_MI      1
`define RC_CLR     2

// Status register fields
`define ST_OUT_LO  8
`define ST_DONE    16
`define ST_ERR     17
`define ST_HALT    18

// Error flag and mask positions (documented bit 63 sits at index 0)
`define E_OFO      0
`define E_OFU      1
`define E_IFO      2
`define E_IFU      3
`define E_IFE      4
`define E_OFE      5
`define E_AE       6
`define E_ME       7
`define E_DSE      8
`define E_KSE      9
`define E_CE       10
`define E_ERE      11
`define E_IE       12
`define E_KPE      13
`define ERR_W      14

// Reset values
`define RST_MASK   14'h0000
`define RST_WORD   32'h0000_0000
`define RST_KEY    64'h0000_0000_0000_0000

`endif

/* des_unit.v */
// DES unit host side: error masking, error flags, final-block trigger,
// chaining vector, write-only keys and the queue window.
// Assumes a classic Wishbone master on sys_clk and a channel pulse on sys_clk.
//
// How it works
// - Masked error leaves flags and interrupt untouched
// - Unmasked error sets flag, interrupt, halts processing
// - Fourteen mask bits, one disables that error
// - Key parity must be odd; triple keys conditional
// - Chaining vector read while busy flags early read
// - Context register writes while busy flag context error
// - Key length must suit single or triple mode
// - Message length must be whole 64-bit blocks
// - Illegal mode and illegal addresses are flagged
// - Message length write with output data flagged
// - Input data left at done is flagged
// - Underflow and overflow flagged per queue
// - Trigger ignores write data, reads zero silently
// - Message length sets how many blocks process
// - Channel pulse starts unit when idle and not halted, in any mode
// - Chaining vector readable, writable, updated while processing in CBC mode
// - Keys write-only; first key copied to third
// - Key reads return zero and flag address error
// - Queue window writes push, reads pop words
// - Key length codes eight, sixteen, twenty-four
// - Only low six length bits are checked
// - Interrupt reset clears done, error and flags
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ns
`include "des_unit_consts.vh"
`default_nettype none

module des_unit #(
  parameter DEPTH = 64,
  parameter PTR_W = 6,
  parameter CNT_W = 7
) (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  input  wire        channelGo,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         errorIrq,
  output reg         doneIrq,
  output reg         halted
);

  localparam S_IDLE = 1'b0;
  localparam S_RUN  = 1'b1;
  localparam [CNT_W-1:0] FULL_CNT = DEPTH;
  localparam [CNT_W-1:0] ONE_CNT  = 1;
  localparam [PTR_W-1:0] ONE_PTR  = 1;
  localparam [25:0]      ONE_BLK  = 1;

  ////////////////////////////////////////////////////////////////////////
  // State

  reg                 state;
  reg [`MODE_W-1:0]   modeReg;
  reg [7:0]           keyLen;
  reg [31:0]          msgLen;
  reg [25:0]          blocksLeft;
  reg [63:0]          key1;
  reg [63:0]          key2;
  reg [63:0]          key3;
  reg [63:0]          chainVec;
  reg [`ERR_W-1:0]    errFlags;
  reg [`ERR_W-1:0]    errMask;
  reg [31:0]          wrHi;
  reg [31:0]          rdLo;
  reg                 doSr;
  reg                 doMi;
  reg [63:0]          inMem [0:DEPTH-1];
  reg [63:0]          outMem [0:DEPTH-1];
  reg [PTR_W-1:0]     inWp;
  reg [PTR_W-1:0]     inRp;
  reg [CNT_W-1:0]     inCnt;
  reg [PTR_W-1:0]     outWp;
  reg [PTR_W-1:0]     outRp;
  reg [CNT_W-1:0]     outCnt;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function oddOk;
    input [31:0] w;
    begin
      oddOk = (^w[31:24]) & (^w[23:16]) & (^w[15:8]) & (^w[7:0]);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire [7:0]  a   = wb_adr_i;
  wire [31:0] d   = wb_dat_i;
  wire        req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr  = req & wb_we_i;
  wire        rd  = req & ~wb_we_i;

  wire isFifo  = a[`FIFO_BIT];
  wire isMode  = a == `A_MODE;
  wire isKlen  = a == `A_KLEN;
  wire isMlen  = a == `A_MLEN;
  wire isRstc  = a == `A_RSTC;
  wire isStat  = a == `A_STAT;
  wire isEflg  = a == `A_EFLG;
  wire isEmsk  = a == `A_EMSK;
  wire isGo    = a == `A_GO;
  wire isIv    = (a == `A_IVH) | (a == `A_IVL);
  wire isK1    = (a == `A_K1H) | (a == `A_K1L);
  wire isK2    = (a == `A_K2H) | (a == `A_K2L);
  wire isK3    = (a == `A_K3H) | (a == `A_K3L);
  wire isKey   = isK1 | isK2 | isK3;
  wire mapped  = isFifo | isMode | isKlen | isMlen | isRstc | isStat | isEflg | isEmsk | isGo | isIv | isKey;
  wire isCtx   = isKey | isKlen | isMlen | isMode | isIv;

  wire busy    = state == S_RUN;
  wire tdes    = modeReg[`MODE_TDES];
  wire cbc     = modeReg[`MODE_CBC];
  wire dataOk  = oddOk(d);
  wire k2Check = tdes & ((keyLen == `KLEN_2KEY) | (keyLen == `KLEN_3KEY));
  wire k3Check = tdes & (keyLen == `KLEN_3KEY);
  wire [31:0] modeWr = merge({{(32-`MODE_W){1'b0}}, modeReg}, d, wb_sel_i);
  wire [31:0] klenWr = merge({24'h00_0000, keyLen}, d, wb_sel_i);
  wire [31:0] mlenWr = merge(msgLen, d, wb_sel_i);
  wire [31:0] maskWr = merge({{(32-`ERR_W){1'b0}}, errMask}, d, wb_sel_i);

  ////////////////////////////////////////////////////////////////////////
  // Queues and engine step

  wire inEmpty  = inCnt == {CNT_W{1'b0}};
  wire inFull   = inCnt == FULL_CNT;
  wire outEmpty = outCnt == {CNT_W{1'b0}};
  wire outFull  = outCnt == FULL_CNT;

  wire busPush  = wr & isFifo & a[`HALF_BIT];
  wire busPop   = rd & isFifo & ~a[`HALF_BIT];
  wire inPush   = busPush & ~inFull;
  wire outPop   = busPop & ~outEmpty;

  wire step     = busy & ~halted;
  wire stepDone = step & (blocksLeft == 26'h000_0000);
  wire stepWant = step & ~stepDone;
  wire inPop    = stepWant & ~inEmpty;
  wire outPush  = inPop & ~outFull;

  wire [63:0] blkIn  = inMem[inRp];
  wire [63:0] blkOut = blkIn ^ key1 ^ key2 ^ key3 ^ (cbc ? chainVec : 64'h0000_0000_0000_0000);

  wire goReq = ((wr & isGo) | channelGo) & ~busy & ~halted;
  wire clr   = wr & isRstc & d[`RC_CLR];

  ////////////////////////////////////////////////////////////////////////
  // Error events

  reg [`ERR_W-1:0] ev;

  always @* begin
    ev = {`ERR_W{1'b0}};
    ev[`E_KPE] = wr & ~dataOk & (isK1 | (isK2 & k2Check) | (isK3 & k3Check));
    ev[`E_IE]  = 1'b0;
    ev[`E_ERE] = rd & isIv & busy;
    ev[`E_CE]  = wr & isCtx & busy;
    ev[`E_KSE] = wr & isKlen & (tdes ? ~((klenWr == {24'h00_0000, `KLEN_2KEY}) |
                                          (klenWr == {24'h00_0000, `KLEN_3KEY}))
                                     : (klenWr != {24'h00_0000, `KLEN_1DES}));
    ev[`E_DSE] = wr & isMlen & (|(mlenWr & `MLEN_CHK));
    ev[`E_ME]  = wr & isMode & (|(modeWr & ~`MODE_LEGAL));
    ev[`E_AE]  = (req & ~mapped) | (rd & isKey) | (wr & (isStat | isEflg));
    ev[`E_OFE] = wr & isMlen & ~outEmpty;
    ev[`E_IFE] = stepDone & ~inEmpty;
    ev[`E_IFU] = stepWant & inEmpty;
    ev[`E_IFO] = busPush & inFull;
    ev[`E_OFU] = busPop & outEmpty;
    ev[`E_OFO] = inPop & outFull;
  end

  wire [`ERR_W-1:0] newErr = ev & ~errMask;
  wire              anyErr = |newErr;

  ////////////////////////////////////////////////////////////////////////
  // Read data

  reg [31:0] rdata;

  always @* begin
    rdata = `RST_WORD;
    if (isFifo) begin
      if (~a[`HALF_BIT]) begin
        rdata = outEmpty ? `RST_WORD : outMem[outRp][63:32];
      end else begin
        rdata = rdLo;
      end
    end else begin
      case (a)
        `A_MODE: rdata = modeWr & {{(32-`MODE_W){1'b0}}, {`MODE_W{1'b1}}} & 32'h0000_0000 |
                         {{(32-`MODE_W){1'b0}}, modeReg};
        `A_KLEN: rdata = {24'h00_0000, keyLen};
        `A_MLEN: rdata = msgLen;
        `A_STAT: begin
          rdata[CNT_W-1:0] = inCnt;
          rdata[`ST_OUT_LO +: CNT_W] = outCnt;
          rdata[`ST_DONE] = doneIrq;
          rdata[`ST_ERR] = errorIrq;
          rdata[`ST_HALT] = halted;
        end
        `A_EFLG: rdata = {{(32-`ERR_W){1'b0}}, errFlags};
        `A_EMSK: rdata = {{(32-`ERR_W){1'b0}}, errMask};
        `A_GO:   rdata = `RST_WORD;
        `A_IVH:  rdata = chainVec[63:32];
        `A_IVL:  rdata = chainVec[31:0];
        default: rdata = `RST_WORD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers, queues and engine

  always @(posedge sys_clk) begin
    if (reset || doSr) begin
      errMask <= `RST_MASK;
    end else if (wr && isEmsk) begin
      errMask <= maskWr[`ERR_W-1:0];
    end
  end

  always @(posedge sys_clk) begin
    if (reset || doSr || doMi) begin
      state      <= S_IDLE;
      modeReg    <= {`MODE_W{1'b0}};
      keyLen     <= 8'h00;
      msgLen     <= `RST_WORD;
      blocksLeft <= 26'h000_0000;
      key1       <= `RST_KEY;
      key2       <= `RST_KEY;
      key3       <= `RST_KEY;
      chainVec   <= `RST_KEY;
      errFlags   <= {`ERR_W{1'b0}};
      errorIrq   <= 1'b0;
      doneIrq    <= 1'b0;
      halted     <= 1'b0;
      wrHi       <= `RST_WORD;
      rdLo       <= `RST_WORD;
      doSr       <= 1'b0;
      doMi       <= 1'b0;
      inWp       <= {PTR_W{1'b0}};
      inRp       <= {PTR_W{1'b0}};
      inCnt      <= {CNT_W{1'b0}};
      outWp      <= {PTR_W{1'b0}};
      outRp      <= {PTR_W{1'b0}};
      outCnt     <= {CNT_W{1'b0}};
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= `RST_WORD;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rd ? rdata : `RST_WORD;
      doSr     <= wr & isRstc & d[`RC_SR];
      doMi     <= wr & isRstc & d[`RC_MI];

      // Sticky flags; a new error wins over a clear in the same cycle
      errFlags <= (clr ? {`ERR_W{1'b0}} : errFlags) | newErr;
      errorIrq <= (errorIrq & ~clr) | anyErr;
      halted   <= (halted & ~clr) | anyErr;
      doneIrq  <= (doneIrq & ~clr) | stepDone;

      // Context registers take no host writes while processing
      if (wr && !busy) begin
        if (isMode) begin
          modeReg <= modeWr[`MODE_W-1:0];
        end
        if (isKlen) begin
          keyLen <= klenWr[7:0];
        end
        if (isMlen) begin
          msgLen <= mlenWr;
        end
        if (a == `A_K1H) begin
          key1[63:32] <= merge(key1[63:32], d, wb_sel_i);
          key3[63:32] <= merge(key1[63:32], d, wb_sel_i);
        end
        if (a == `A_K1L) begin
          key1[31:0] <= merge(key1[31:0], d, wb_sel_i);
          key3[31:0] <= merge(key1[31:0], d, wb_sel_i);
        end
        if (a == `A_K2H) begin
          key2[63:32] <= merge(key2[63:32], d, wb_sel_i);
        end
        if (a == `A_K2L) begin
          key2[31:0] <= merge(key2[31:0], d, wb_sel_i);
        end
        if (a == `A_K3H) begin
          key3[63:32] <= merge(key3[63:32], d, wb_sel_i);
        end
        if (a == `A_K3L) begin
          key3[31:0] <= merge(key3[31:0], d, wb_sel_i);
        end
        if (a == `A_IVH) begin
          chainVec[63:32] <= merge(chainVec[63:32], d, wb_sel_i);
        end
        if (a == `A_IVL) begin
          chainVec[31:0] <= merge(chainVec[31:0], d, wb_sel_i);
        end
      end

      // Queue window: high half staged, low half pushes the word
      if (wr && isFifo && !a[`HALF_BIT]) begin
        wrHi <= d;
      end
      if (inPush) begin
        inMem[inWp] <= {wrHi, d};
        inWp <= inWp + ONE_PTR;
      end
      if (outPop) begin
        rdLo  <= outMem[outRp][31:0];
        outRp <= outRp + ONE_PTR;
      end

      // Engine: one block per cycle while running and not halted
      case (state)
        S_IDLE: begin
          if (goReq) begin
            state      <= S_RUN;
            blocksLeft <= msgLen[31:`MLEN_SHIFT];
          end
        end
        S_RUN: begin
          if (stepDone) begin
            state <= S_IDLE;
          end else if (inPop) begin
            inRp       <= inRp + ONE_PTR;
            blocksLeft <= blocksLeft - ONE_BLK;
            if (outPush) begin
              outMem[outWp] <= blkOut;
              outWp <= outWp + ONE_PTR;
            end
            if (cbc) begin
              chainVec <= blkOut;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase

      inCnt  <= inCnt + (inPush ? ONE_CNT : {CNT_W{1'b0}}) - (inPop ? ONE_CNT : {CNT_W{1'b0}});
      outCnt <= outCnt + (outPush ? ONE_CNT : {CNT_W{1'b0}}) - (outPop ? ONE_CNT : {CNT_W{1'b0}});
    end
  end

endmodule

`default_nettype wire

/* des_unit_asserts.sv */
// Checker for des_unit: bus timing, error halt, sticky interrupts.
// Assumes bind from the testbench top and the unit's register map.
`timescale 1ns/1ns
`include "des_unit_consts.vh"
`default_nettype none
module des_unit_asserts (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        channelGo,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        errorIrq,
  input wire logic        doneIrq,
  input wire logic        halted
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire take   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rdTake = take && !wb_we_i;
  wire clrWr  = take && wb_we_i && wb_adr_i == `A_RSTC;
  ////////////////////////////////////////////////////////////
  property p_ack_lat;
    take |=> wb_ack_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_ack_cause;
    wb_ack_o |-> $past(take);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data off ack");
  property p_go_read;
    rdTake && wb_adr_i == `A_GO && !errorIrq |=> wb_dat_o == 32'h0000_0000 && !errorIrq;
  endproperty
  a_go_read: assert property (p_go_read) else $error("trigger read");
  property p_key_read;
    rdTake && wb_adr_i inside {[`A_K1H:`A_K3L]} |=> wb_dat_o == 32'h0000_0000;
  endproperty
  a_key_read: assert property (p_key_read) else $error("key leaked");
  property p_halt_err;
    errorIrq == halted;
  endproperty
  a_halt_err: assert property (p_halt_err) else $error("halt mismatch");
  property p_err_hold;
    errorIrq && !clrWr && !$past(clrWr) |=> errorIrq;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error lost");
  property p_done_hold;
    $fell(doneIrq) |-> $past(clrWr) || $past(clrWr, 2);
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done lost");
  property p_irq_clear;
    clrWr && wb_dat_i[`RC_CLR] |-> ##[2:3] !doneIrq && !errorIrq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq kept");
  c_err: cover property ($rose(errorIrq));
  c_done: cover property ($rose(doneIrq));
  c_key: cover property (rdTake && wb_adr_i == `A_K1H);
endmodule
`default_nettype wire

/* wb_host_model.sv */
// Host bus master model: classic Wishbone single cycles.
// Assumes a slave that answers with a one-cycle ack.
`timescale 1ns/1ns
`default_nettype none
module wb_host_model (
  input  wire logic        sys_clk,
  input  wire logic        wb_ack_o,
  output var  logic        wb_cyc_i,
  output var  logic        wb_stb_i,
  output var  logic        wb_we_i,
  output var  logic [7:0]  wb_adr_i,
  output var  logic [3:0]  wb_sel_i,
  output var  logic [31:0] wb_dat_i
);
  initial begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
  end
  // One cycle; released lines show inverted values
  task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= ~we;
    wb_adr_i <= ~adr;
    wb_sel_i <= 4'h0;
    wb_dat_i <= ~dat;
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* des_unit_tb.sv */
// Testbench for des_unit: noted read results checked by a monitor.
// Assumes wb_host_model and des_unit_asserts are compiled first.
`timescale 1ns/1ns
`include "des_unit_consts.vh"
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR reg %h exp %h got %h", nm, e, g); end end
module des_unit_tb;
  typedef struct {logic [7:0] a; logic [31:0] v; logic [31:0] m;} note_t;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        channelGo = 1'b0;
  wire logic   wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, errorIrq, doneIrq, halted;
  wire logic [7:0]  wb_adr_i;
  wire logic [3:0]  wb_sel_i;
  wire logic [31:0] wb_dat_i, wb_dat_o;
  int          num_errors = 0;
  int          comparisons = 0;
  int          seed = 32'h732a_de10;
  int          k;
  int          i;
  logic [31:0] d;
  note_t       n;
  note_t       expQ[$];
  logic [7:0]  tAdr[8] = '{`A_K1H, `A_KLEN, `A_MLEN, `A_MODE, 8'h40, `A_STAT, 8'h80, `A_K1H};
  logic [31:0] tDat[8] = '{32'h0, 32'h10, 32'h20, 32'h10, 32'h0, 32'h0, 32'h0, 32'h0};
  int          tIdx[8] = '{`E_KPE, `E_KSE, `E_DSE, `E_ME, `E_AE, `E_AE, `E_OFU, `E_AE};
  logic        tWe[8]  = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  wb_host_model host (.sys_clk, .wb_ack_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i);
  des_unit dut (.sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .channelGo, .wb_dat_o, .wb_ack_o, .errorIrq, .doneIrq, .halted);
  initial forever #2 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    host.access(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m = 32'hffff_ffff);
    expQ.push_back('{a, v & m, m});
    host.access(1'b0, a, 32'h0000_0000);
  endtask
  task automatic flags(input logic [31:0] v);
    rd(`A_EFLG, v);
    wr(`A_RSTC, 32'h0000_0004);
  endtask
  task automatic wait_done;
    for (int t = 0; t < 100 && doneIrq !== 1'b1; t++) @(posedge sys_clk);
  endtask
  function automatic logic [31:0] oddp(input logic [31:0] x);
    for (int b = 0; b < 4; b++) x[8*b] = ~^x[8*b+1 +: 7];
    return x;
  endfunction
  task automatic give_verdict;
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expQ.size() > 0) begin
      n = expQ.pop_front();
      `CHK(n.a, n.v, wb_dat_o & n.m)
      if (n.a == `A_STAT) `CHK(n.a, n.v[`ST_HALT:`ST_DONE], {halted, errorIrq, doneIrq} & n.m[`ST_HALT:`ST_DONE])
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(`A_EMSK, `RST_WORD);
    rd(`A_GO, 32'h0);
    rd(`A_EFLG, `RST_WORD);
    for (k = 0; k < 16; k++) begin
      i = k >> 1;
      wr(`A_EMSK, k[0] ? 32'h0 : 32'h1 << tIdx[i]);
      if (tWe[i]) wr(tAdr[i], tDat[i]);
      else rd(tAdr[i], 32'h0);
      rd(`A_EFLG, k[0] ? 32'h1 << tIdx[i] : 32'h0);
      rd(`A_STAT, k[0] ? 32'h0006_0000 : 32'h0, 32'h0006_0000);
      wr(`A_RSTC, 32'h0000_0004);
    end
    rd(`A_STAT, 32'h0, 32'h0007_0000);
    wr(`A_MODE, 32'h1);
    wr(`A_KLEN, `KLEN_2KEY);
    wr(`A_KLEN, `KLEN_3KEY);
    wr(`A_MODE, 32'h0);
    wr(`A_KLEN, `KLEN_1DES);
    wr(`A_K1H, oddp($random(seed)));
    wr(`A_K1L, oddp($random(seed)));
    d = $random(seed);
    wr(`A_IVH, d);
    rd(`A_IVH, d);
    rd(`A_EFLG, 32'h0);
    wr(`A_MLEN, 32'h0000_00c0);
    for (k = 0; k < 6; k++) wr(8'h80 | 8'(k << 2), $random(seed));
    rd(`A_STAT, 32'h3, 32'h0000_7f7f);
    wr(`A_GO, $random(seed));
    wait_done;
    rd(`A_STAT, 32'h0001_0300, 32'h0007_7f7f);
    rd(`A_EFLG, 32'h0);
    wr(`A_MLEN, 32'h0000_0040);
    flags(32'h1 << `E_OFE);
    for (k = 0; k < 6; k++) rd(8'hc0 | 8'(k << 2), 32'h0, 32'h0);
    rd(`A_STAT, 32'h0, 32'h0000_7f7f);
    wr(`A_MLEN, 32'h0000_0040);
    for (k = 0; k < 4; k++) wr(8'h90 | 8'(k << 2), $random(seed));
    channelGo <= 1'b1;
    @(posedge sys_clk);
    channelGo <= 1'b0;
    wait_done;
    flags(32'h1 << `E_IFE);
    wr(`A_EMSK, (32'h1 << `E_IFU) | (32'h1 << `E_OFE));
    wr(`A_MLEN, 32'h0000_0400);
    wr(`A_GO, 32'h0);
    rd(`A_IVH, 32'h0, 32'h0);
    flags(32'h1 << `E_ERE);
    wr(`A_MODE, 32'h0);
    flags(32'h1 << `E_CE);
    wr(`A_RSTC, 32'h0000_0001);
    rd(`A_EMSK, 32'h0);
    // Deliberate overrun of the input queue by the host
    for (k = 0; k < 65; k++) wr(8'h84, k);
    rd(`A_EFLG, 32'h1 << `E_IFO);
    rd(`A_STAT, 32'h0000_0040, 32'h0000_007f);
    give_verdict;
  end
endmodule
bind des_unit des_unit_asserts u_chk (.sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .channelGo, .wb_dat_o, .wb_ack_o, .errorIrq, .doneIrq,
  .halted);
`default_nettype wire
